/* sap_pkg.sv */
// Shared constants, types and helpers for the serial audio port link
package sap_pkg;

   // Link shape
   localparam int NUM_IN    = 5;
   localparam int HALF_BITS = 32;
   localparam int WORD_W    = 24;
   localparam int FCNT_W    = 14;
   localparam int MCNT_W    = 10;
   localparam logic [5:0] K_LAST    = 6'h1F;
   localparam logic [5:0] I2S_DELAY = 6'h01;
   localparam logic [5:0] WLB_16    = 6'h10;
   localparam logic [5:0] WLB_20    = 6'h14;
   localparam logic [5:0] WLB_24    = 6'h18;
   localparam logic [1:0] LOCK_FRAMES = 2'h2;
   localparam logic [3:0] CH_NORMAL   = 4'h8;
   localparam logic [3:0] CH_QUAD     = 4'h4;

   // Synchronised pin bundle positions in the receiver
   localparam int SYNC_W = 9;
   localparam int B_PWR  = 8;
   localparam int B_MCLK = 7;
   localparam int B_BCLK = 6;
   localparam int B_WS   = 5;

   // Clock and rate figures
   localparam int CORE_HZ     = 200_000_000;
   localparam int MCLK_MAX_HZ = 50_000_000;
   localparam int FSHZ_32  = 32000;
   localparam int FSHZ_44  = 44100;
   localparam int FSHZ_48  = 48000;
   localparam int FSHZ_88  = 88200;
   localparam int FSHZ_96  = 96000;
   localparam int FSHZ_176 = 176400;
   localparam int FSHZ_192 = 192000;
   localparam int P_32  = CORE_HZ / FSHZ_32;
   localparam int P_44  = CORE_HZ / FSHZ_44;
   localparam int P_48  = CORE_HZ / FSHZ_48;
   localparam int P_88  = CORE_HZ / FSHZ_88;
   localparam int P_96  = CORE_HZ / FSHZ_96;
   localparam int P_176 = CORE_HZ / FSHZ_176;
   localparam int P_192 = CORE_HZ / FSHZ_192;
   localparam int TIMEOUT_DEF = 2 * P_32;
   localparam logic [7:0] MCLK_HALF_MIN = 8'(CORE_HZ / (2 * MCLK_MAX_HZ));
   localparam logic [7:0] BCLK_HALF_48K = 8'(CORE_HZ / (2 * 64 * FSHZ_48));
   localparam logic [7:0] BCLK_HALF_MIN = 8'h08;
   localparam int MR_64  = 64;
   localparam int MR_128 = 128;
   localparam int MR_192 = 192;
   localparam int MR_256 = 256;
   localparam int MR_384 = 384;
   localparam int MR_512 = 512;

   typedef enum logic [1:0] {FMT_RJ, FMT_I2S, FMT_LJ} sap_fmt_t;
   typedef enum logic [1:0] {WL_16, WL_20, WL_24} sap_wl_t;
   typedef enum logic [2:0] {FS_NONE, FS_32, FS_44, FS_48, FS_88, FS_96, FS_176,
                             FS_192} sap_rate_t;
   typedef enum logic [2:0] {MCK_64, MCK_128, MCK_192, MCK_256, MCK_384,
                             MCK_512} sap_mck_t;

   function automatic logic [5:0] sap_wl_bits(input sap_wl_t w);
      if (w == WL_16) return WLB_16;
      if (w == WL_20) return WLB_20;
      return WLB_24;
   endfunction

   // Bit slot of the word MSB after the word-select edge
   function automatic logic [5:0] sap_k0(input sap_fmt_t f, input sap_wl_t w);
      if (f == FMT_I2S) return I2S_DELAY;
      if (f == FMT_LJ) return '0;
      return 6'(HALF_BITS) - sap_wl_bits(w);
   endfunction

   function automatic logic [WORD_W-1:0] sap_mask(input sap_wl_t w);
      return {WORD_W{1'b1}} << (6'(WORD_W) - sap_wl_bits(w));
   endfunction

   // Half-frame bits (slot k at bit 31-k) to a left-aligned word
   function automatic logic [WORD_W-1:0] sap_extract(input logic [HALF_BITS-1:0] s,
                                                     input sap_fmt_t f, input sap_wl_t w);
      logic [HALF_BITS+WORD_W-1:0] t;
      t = {s, {WORD_W{1'b0}}} << sap_k0(f, w);
      return t[HALF_BITS+WORD_W-1 -: WORD_W] & sap_mask(w);
   endfunction

   // Left-aligned word to half-frame bits, inverse of the above
   function automatic logic [HALF_BITS-1:0] sap_place(input logic [WORD_W-1:0] d,
                                                      input sap_fmt_t f, input sap_wl_t w);
      logic [HALF_BITS+WORD_W-1:0] t;
      t = {d & sap_mask(w), {HALF_BITS{1'b0}}} >> sap_k0(f, w);
      return t[HALF_BITS+WORD_W-1 -: HALF_BITS];
   endfunction

   // Frame length in core cycles to sample rate, midpoint thresholds
   function automatic sap_rate_t sap_rate_of(input logic [FCNT_W-1:0] n);
      if (n < FCNT_W'((P_192 + P_176) / 2)) return FS_192;
      if (n < FCNT_W'((P_176 + P_96) / 2)) return FS_176;
      if (n < FCNT_W'((P_96 + P_88) / 2)) return FS_96;
      if (n < FCNT_W'((P_88 + P_48) / 2)) return FS_88;
      if (n < FCNT_W'((P_48 + P_44) / 2)) return FS_48;
      if (n < FCNT_W'((P_44 + P_32) / 2)) return FS_44;
      return FS_32;
   endfunction

   // Master clock edges per frame to ratio
   function automatic sap_mck_t sap_mck_of(input logic [MCNT_W-1:0] n);
      if (n < MCNT_W'((MR_64 + MR_128) / 2)) return MCK_64;
      if (n < MCNT_W'((MR_128 + MR_192) / 2)) return MCK_128;
      if (n < MCNT_W'((MR_192 + MR_256) / 2)) return MCK_192;
      if (n < MCNT_W'((MR_256 + MR_384) / 2)) return MCK_256;
      if (n < MCNT_W'((MR_384 + MR_512) / 2)) return MCK_384;
      return MCK_512;
   endfunction

endpackage

/* sap_link_if.sv */
// Link wires between the audio source and the serial audio port
`timescale 1ns/1ps
interface sap_link_if;
   import sap_pkg::*;
   logic              mclk;   // Master clock
   logic              bclk;   // Bit clock, 64 per frame
   logic              ws;     // Word select, low = left
   logic [NUM_IN-1:0] sdin;   // Serial inputs a1, a2, b1, b2, direct
   logic              serial_audio_out; // Serial audio out, I2S 24-bit
   modport dev (input mclk, input bclk, input ws, input sdin, output serial_audio_out);
   modport src (output mclk, output bclk, output ws, output sdin, input serial_audio_out);
endinterface

/* sap_src.sv */
// Audio source end: makes the clocks, drives the inputs, reads the output
`timescale 1ns/1ps
module sap_src
   import sap_pkg::*;
(
   input  wire logic                                 core_clk_i,
   input  wire logic                                 resetn_i,
   input  wire logic                                 ce_i,
   sap_link_if.src                                   lk,
   input  wire logic [7:0]                           bclk_half_i,
   input  wire logic [7:0]                           mclk_half_i,
   input  wire sap_fmt_t                             fmt_i,
   input  wire sap_wl_t                              wl_i,
   input  wire logic [NUM_IN-1:0][1:0][WORD_W-1:0]   tx_sample_i,
   output logic                                      sample_req_o,
   output logic [WORD_W-1:0]                         rx_sample_o,
   output logic                                      rx_right_o,
   output logic                                      rx_valid_o
);

   typedef struct packed {
      logic [7:0]                        bdiv;
      logic [7:0]                        mdiv;
      logic                              mclk;
      logic                              bclk;
      logic                              ws;
      logic [5:0]                        k;
      logic [NUM_IN-1:0][HALF_BITS-1:0]  pat;
      logic [NUM_IN-1:0]                 sdin;
      logic                              s1;
      logic                              s2;
      logic [HALF_BITS-1:0]              rsr;
      logic [WORD_W-1:0]                 rx;
      logic                              rx_right;
      logic                              rx_valid;
      logic                              req;
   } sap_src_st_t;

   sap_src_st_t r;
   sap_src_st_t next_r;

   logic [7:0]                        bh;
   logic [7:0]                        mh0;
   logic [7:0]                        mh;
   logic [5:0]                        nk;
   logic [HALF_BITS-1:0]              rin;
   logic [NUM_IN-1:0][HALF_BITS-1:0]  npat;

   ////////////////////////////////////////////////////////////////////////////
   // Clock ratio guards; a slow bit clock leaves room for two sync stages
   assign bh  = (bclk_half_i < BCLK_HALF_MIN) ? BCLK_HALF_MIN : bclk_half_i;
   assign mh0 = (mclk_half_i < MCLK_HALF_MIN) ? MCLK_HALF_MIN : mclk_half_i;
   assign mh  = (mh0 == bh && bh > BCLK_HALF_48K) ? (bh >> 1) : mh0;
   assign nk  = r.k + 6'h01;
   assign rin = {r.rsr[HALF_BITS-2:0], r.s2};

   // framing per input, MSB first in its slot
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_pat
         assign npat[gi] = (nk[4:0] == 5'h00) ?
                           sap_place(tx_sample_i[gi][nk[5]], fmt_i, wl_i) : r.pat[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.s1 = lk.serial_audio_out;
      next_r.s2 = r.s1;
      next_r.req = 1'b0;
      next_r.rx_valid = 1'b0;
      if (r.mdiv >= mh - 8'h01) begin
         next_r.mdiv = '0;
         next_r.mclk = ~r.mclk;
      end else begin
         next_r.mdiv = r.mdiv + 8'h01;
      end
      if (r.bdiv >= bh - 8'h01) begin
         next_r.bdiv = '0;
         next_r.bclk = ~r.bclk;
         if (r.bclk) begin
            // one bit clock, 64 slots, drives all inputs
            next_r.k = nk;
            next_r.ws = nk[5];
            next_r.req = (nk == 6'h00);
            for (int i = 0; i < NUM_IN; i++) begin
               next_r.sdin[i] = npat[i][HALF_BITS-1];
               next_r.pat[i] = npat[i] << 1;
            end
         end else begin
            next_r.rsr = rin;
            if (r.k[4:0] == K_LAST[4:0]) begin
               next_r.rx = sap_extract(rin, FMT_I2S, WL_24);
               next_r.rx_right = r.k[5];
               next_r.rx_valid = 1'b1;
            end
         end
      end else begin
         next_r.bdiv = r.bdiv + 8'h01;
      end
   end

   // State register; slot counter starts at the end of a frame
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         r <= '0;
         r.k <= '1;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign lk.mclk = r.mclk;
   assign lk.bclk = r.bclk;
   assign lk.ws   = r.ws;
   assign lk.sdin = r.sdin;
   assign sample_req_o = r.req;
   assign rx_sample_o  = r.rx;
   assign rx_right_o   = r.rx_right;
   assign rx_valid_o   = r.rx_valid;

endmodule

/* sap_dev.sv */
// Serial audio port receive end: five inputs, rate detect, one output
`timescale 1ns/1ps
module sap_dev
   import sap_pkg::*;
#(
   parameter logic [FCNT_W-1:0] FRAME_TIMEOUT = FCNT_W'(TIMEOUT_DEF)
)
(
   input  wire logic                               core_clk_i,
   input  wire logic                               resetn_i,
   input  wire logic                               ce_i,
   sap_link_if.dev                                 lk,
   input  wire logic                               power_down_pin_n_i,
   input  wire logic                               cfg_manual_i,
   input  wire sap_fmt_t                           cfg_fmt_i,
   input  wire sap_wl_t                            cfg_wl_i,
   input  wire logic [WORD_W-1:0]                  tx_left_i,
   input  wire logic [WORD_W-1:0]                  tx_right_i,
   output logic [NUM_IN-1:0][WORD_W-1:0]           sample_o,
   output logic                                    sample_right_o,
   output logic                                    sample_valid_o,
   output sap_rate_t                               rate_o,
   output sap_mck_t                                mclk_ratio_o,
   output logic                                    locked_o,
   output logic                                    error_o,
   output logic                                    quad_speed_o,
   output logic [3:0]                              proc_channels_o
);

   typedef struct packed {
      logic [SYNC_W-1:0]                 s1;
      logic [SYNC_W-1:0]                 s2;
      logic [SYNC_W-1:0]                 s3;
      logic                              ws_last;
      logic [5:0]                        k;
      logic [NUM_IN-1:0][HALF_BITS-1:0]  sr;
      logic [FCNT_W-1:0]                 fcnt;
      logic [MCNT_W-1:0]                 mcnt;
      logic                              ferr;
      logic [1:0]                        lock;
      logic                              locked;
      logic                              tx_ws;
      logic [HALF_BITS-1:0]              tx_sr;
      logic                              ser_out;
      logic [NUM_IN-1:0][WORD_W-1:0]     smp;
      logic                              smp_right;
      logic                              smp_valid;
      sap_rate_t                         rate;
      sap_mck_t                          mck;
      logic                              err;
      logic                              quad;
      logic [3:0]                        chans;
   } sap_dev_st_t;

   sap_dev_st_t r;
   sap_dev_st_t next_r;

   sap_fmt_t                          fmt;
   sap_wl_t                           wl;
   logic                              live;
   logic                              b_rise;
   logic                              b_fall;
   logic                              m_rise;
   logic                              ws_chg;
   logic                              ferr_now;
   logic                              quad_now;
   sap_rate_t                         rate_now;
   logic [HALF_BITS-1:0]              tx_pat;
   logic [NUM_IN-1:0][WORD_W-1:0]     ext;
   logic [NUM_IN-1:0][HALF_BITS-1:0]  shf;

   ////////////////////////////////////////////////////////////////////////////
   // Effective framing: without an override the port assumes I2S 24-bit,
   // since framing cannot be told apart from the data itself
   // override or default
   assign fmt = cfg_manual_i ? cfg_fmt_i : FMT_I2S;
   assign wl  = cfg_manual_i ? cfg_wl_i : WL_24;

   // Edges are taken from the second and third stages only
   assign live   = r.s2[B_PWR];
   assign b_rise = r.s2[B_BCLK] & ~r.s3[B_BCLK];
   assign b_fall = ~r.s2[B_BCLK] & r.s3[B_BCLK];
   assign m_rise = r.s2[B_MCLK] & ~r.s3[B_MCLK];
   assign ws_chg = r.s2[B_WS] != r.ws_last;

   // Frame check: each half must carry exactly 32 bit clocks
   // slot count check
   assign ferr_now = r.ferr | (r.k != K_LAST);
   assign rate_now = sap_rate_of(r.fcnt);
   assign quad_now = (rate_now == FS_176) || (rate_now == FS_192);

   assign tx_pat = sap_place(r.s2[B_WS] ? tx_right_i : tx_left_i, FMT_I2S, WL_24);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         assign shf[gi] = {r.sr[gi][HALF_BITS-2:0], r.s2[gi]};
         assign ext[gi] = sap_extract(r.sr[gi], fmt, wl);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.s1 = {power_down_pin_n_i, lk.mclk, lk.bclk, lk.ws, lk.sdin};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.smp_valid = 1'b0;
      if (!live) begin
         // link held idle, detection restarts on release
         next_r.k = '0;
         next_r.fcnt = '0;
         next_r.mcnt = '0;
         next_r.ferr = 1'b0;
         next_r.lock = '0;
         next_r.ser_out = 1'b0;
         next_r.ws_last = 1'b0;
         next_r.tx_ws = 1'b0;
      end else begin
         if (m_rise && r.mcnt != {MCNT_W{1'b1}}) begin
            next_r.mcnt = r.mcnt + MCNT_W'(1);
         end
         // lost clock: drop lock, wait for frames
         if (r.fcnt == FRAME_TIMEOUT) begin
            next_r.ferr = 1'b1;
            next_r.lock = '0;
            next_r.rate = FS_NONE;
            next_r.err = 1'b1;
         end else begin
            next_r.fcnt = r.fcnt + FCNT_W'(1);
         end
         if (b_rise) begin
            next_r.sr = shf;
            if (ws_chg) begin
               next_r.ws_last = r.s2[B_WS];
               next_r.k = '0;
               // Half complete: words leave only while locked
               if (r.k != K_LAST) begin
                  next_r.ferr = 1'b1;
               end else if (r.lock == LOCK_FRAMES) begin
                  next_r.smp = ext;
                  next_r.smp_right = r.ws_last;
                  next_r.smp_valid = 1'b1;
                  // quad: one stereo per module, copied
                  if (r.quad) begin
                     next_r.smp[1] = ext[0];
                     next_r.smp[3] = ext[2];
                  end
                  // direct input never copied or converted
                  next_r.smp[NUM_IN-1] = ext[NUM_IN-1];
               end
               // Left half starts: a whole frame has passed
               if (!r.s2[B_WS]) begin
                  // rate and bank from frame counts
                  next_r.rate = rate_now;
                  next_r.mck = sap_mck_of(r.mcnt);
                  next_r.quad = quad_now;
                  next_r.chans = quad_now ? CH_QUAD : CH_NORMAL;
                  next_r.err = ferr_now;
                  next_r.fcnt = '0;
                  next_r.mcnt = '0;
                  next_r.ferr = 1'b0;
                  // relock after clean frames at a steady rate
                  if (ferr_now || rate_now != r.rate) begin
                     next_r.lock = '0;
                  end else if (r.lock != LOCK_FRAMES) begin
                     next_r.lock = r.lock + 2'h1;
                  end
               end
            end else if (r.k != {6{1'b1}}) begin
               next_r.k = r.k + 6'h01;
            end
         end
         if (b_fall) begin
            // new word at each word-select edge
            if (r.s2[B_WS] != r.tx_ws) begin
               next_r.tx_ws = r.s2[B_WS];
               next_r.ser_out = tx_pat[HALF_BITS-1];
               next_r.tx_sr = tx_pat << 1;
            end else begin
               next_r.ser_out = r.tx_sr[HALF_BITS-1];
               next_r.tx_sr = r.tx_sr << 1;
            end
         end
      end
      // Lock flag kept in state so the output comes straight from a flop
      next_r.locked = (next_r.lock == LOCK_FRAMES);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register, frozen while the clock enable is low
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // Outputs straight from state
   assign lk.serial_audio_out = r.ser_out;
   assign sample_o        = r.smp;
   assign sample_right_o  = r.smp_right;
   assign sample_valid_o  = r.smp_valid;
   assign rate_o          = r.rate;
   assign mclk_ratio_o    = r.mck;
   assign locked_o        = r.locked;
   assign error_o         = r.err;
   assign quad_speed_o    = r.quad;
   assign proc_channels_o = r.chans;

endmodule

/* sap_link_assertions.sv */
// Link timing checker for the audio source and the serial audio port
`timescale 1ns/1ps
module sap_link_assertions
   import sap_pkg::*;
(
   input wire logic              core_clk_i,
   input wire logic              resetn_i,
   input wire logic              mclk,
   input wire logic              bclk,
   input wire logic              ws,
   input wire logic [NUM_IN-1:0] sdin,
   input wire logic              serial_audio_out
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       seen;
      logic       bq;
      logic       wq;
   } sap_chk_t;
   sap_chk_t st;
   sap_chk_t next_st;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   //////////////////////////////////////////////////
   // Falls since last word-select edge; seen skips the partial first half
   always_comb begin
      next_st = st;
      next_st.bq = bclk;
      next_st.wq = ws;
      if (st.bq && !bclk) begin
         next_st.cnt = (ws != st.wq) ? 6'h01 : st.cnt + 6'h01;
         next_st.seen = st.seen | (ws != st.wq);
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   //////////////////////////////////////////////////
   // select on fall
   ws_on_fall_a: assert property ($changed(ws) |-> $fell(bclk))
      else $error("word select moved off a bit clock fall");
   data_on_fall_a: assert property ($changed(sdin) |-> $fell(bclk))
      else $error("serial input moved off a bit clock fall");
   out_low_half_a: assert property ($changed(serial_audio_out) |-> !bclk)
      else $error("serial output moved while bit clock high");
   bclk_high_min_a: assert property ($rose(bclk) |=> bclk [*7])
      else $error("bit clock high phase too short");
   bclk_low_min_a: assert property ($fell(bclk) |=> !bclk [*7])
      else $error("bit clock low phase too short");
   half_len_a: assert property ((st.seen && st.bq && !bclk && ws != st.wq)
      |-> st.cnt == 6'h20) else $error("half frame not 32 bit clocks");
   mclk_high_a: assert property ($rose(mclk) |=> mclk)
      else $error("master clock high phase too short");
   mclk_low_a: assert property ($fell(mclk) |=> !mclk)
      else $error("master clock low phase too short");
   // Main traffic: full halves, output data, both clocks
   cover property (st.seen && st.cnt == 6'h20);
   cover property ($rose(serial_audio_out));
   cover property ($rose(mclk) && bclk);
endmodule

/* serial_audio_input_port_bench.sv */
// Bench joining the audio source and the serial audio port over the link
`timescale 1ns/1ps
module serial_audio_input_port_bench;
   import sap_pkg::*;
   logic core_clk_i, resetn_i, src_ce, power_down_n, manual;
   logic sreq, rxr, rxv, sr, sv, lock, err, quad;
   logic [7:0] bh, mh;
   logic [3:0] chans, flg;
   logic [WORD_W-1:0] txl, txr, rxs;
   logic [NUM_IN-1:0][1:0][WORD_W-1:0] txs;
   logic [NUM_IN-1:0][WORD_W-1:0] smp;
   sap_fmt_t fmt;
   sap_wl_t wl;
   sap_rate_t rate;
   sap_mck_t mck;
   int n_fail, cmp_count, seed, i, n;
   // Rate cases: bit clock half, master clock half, expected classes
   logic [7:0] t_bh [7] = '{8'h08, 8'h09, 8'h10, 8'h12, 8'h20, 8'h23, 8'h31};
   logic [7:0] t_mh [7] = '{8'h08, 8'h03, 8'h02, 8'h09, 8'h08, 8'h23, 8'h06};
   sap_rate_t t_rt [7] = '{FS_192, FS_176, FS_96, FS_88, FS_48, FS_44, FS_32};
   sap_mck_t t_mk [7] = '{MCK_64, MCK_192, MCK_512, MCK_128, MCK_256, MCK_128, MCK_512};
   sap_link_if lk ();
   sap_src u_sap_src (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(src_ce), .lk(lk),
      .bclk_half_i(bh), .mclk_half_i(mh), .fmt_i(fmt), .wl_i(wl), .tx_sample_i(txs),
      .sample_req_o(sreq), .rx_sample_o(rxs), .rx_right_o(rxr), .rx_valid_o(rxv));
   // Timeout just above the slowest frame keeps the freeze test short
   sap_dev #(.FRAME_TIMEOUT(14'h1900)) u_sap_dev (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .ce_i(1'b1), .lk(lk), .power_down_pin_n_i(power_down_n),
      .cfg_manual_i(manual), .cfg_fmt_i(fmt), .cfg_wl_i(wl), .tx_left_i(txl),
      .tx_right_i(txr), .sample_o(smp), .sample_right_o(sr), .sample_valid_o(sv),
      .rate_o(rate), .mclk_ratio_o(mck), .locked_o(lock), .error_o(err),
      .quad_speed_o(quad), .proc_channels_o(chans));
   sap_link_assertions u_sap_link_assertions (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .mclk(lk.mclk), .bclk(lk.bclk), .ws(lk.ws), .sdin(lk.sdin),
      .serial_audio_out(lk.serial_audio_out));
   // Waitable flags: 0 word valid, 1 loop-back valid, 2 frame start, 3 locked
   assign flg = {lock, sreq, rxv, sv};
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   //////////////////////////////////////////////////
   // Expected left-aligned word once cut to the word length
   function automatic logic [WORD_W-1:0] trim(input logic [WORD_W-1:0] d, input sap_wl_t w);
      return (w == WL_16) ? {d[23:8], 8'h00} : (w == WL_20) ? {d[23:4], 4'h0} : d;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Bounded wait; a lapse counts as a mismatch and ends the run
   task automatic wait_hi(input int w, input int lim);
      int k = 0;
      while (flg[w] !== 1'b1 && k < lim) begin
         @(negedge core_clk_i);
         k++;
      end
      if (flg[w] !== 1'b1) begin
         check(32'h0, 32'h1);
         finish_test();
      end
   endtask
   task automatic restart(input logic [7:0] b, input logic [7:0] m);
      resetn_i = 1'b0;
      bh = b;
      mh = m;
      repeat (6) @(negedge core_clk_i);
      resetn_i = 1'b1;
   endtask
   // New words each side, then two received and two looped-back words compared
   task automatic words(input logic fresh, input logic q);
      for (int j = 0; j < NUM_IN; j++) begin
         txs[j] = {WORD_W'($random(seed)), WORD_W'($random(seed))};
      end
      txs[4] = {24'h000001, 24'h800000};
      txl = WORD_W'($random(seed));
      txr = WORD_W'($random(seed));
      // Source takes each word at the start of its half, so two frame starts guarantee new data
      repeat (fresh ? 0 : 2) begin
         wait_hi(2, 9000);
         @(negedge core_clk_i);
      end
      wait_hi(3, 30000);
      repeat (2) begin
         wait_hi(0, 9000);
         for (int j = 0; j < NUM_IN; j++) begin
            check(smp[j], trim(txs[(q && j % 2) ? j - 1 : j][sr], wl));
         end
         @(negedge core_clk_i);
      end
      repeat (2) begin
         wait_hi(1, 9000);
         check(rxs, rxr ? txr : txl);
         @(negedge core_clk_i);
      end
   endtask
   //////////////////////////////////////////////////
   initial begin
      seed = 32'hCE060029;
      {src_ce, power_down_n, manual} = 3'h6;
      fmt = FMT_I2S;
      wl = WL_24;
      // Autodetect at every rate; slow rates only checked for class
      for (i = 0; i < 7; i++) begin
         restart(t_bh[i], t_mh[i]);
         if (t_bh[i] < 8'h20)
            words(1'b1, t_rt[i] >= FS_176);
         wait_hi(3, 30000);
         check(rate, t_rt[i]);
         check(mck, t_mk[i]);
         check(quad, t_rt[i] >= FS_176);
         check(chans, (t_rt[i] >= FS_176) ? CH_QUAD : CH_NORMAL);
         check(err, 32'h0);
      end
      $display("rate sweep done");
      // Manual framing, every format and length, quad copies on
      restart(8'h08, 8'h04);
      manual = 1'b1;
      for (i = 0; i < 9; i++) begin
         fmt = sap_fmt_t'(i / 3);
         wl = sap_wl_t'(i % 3);
         words(1'b0, 1'b1);
      end
      $display("format sweep done");
      // Power-down with the link running: no words at all
      power_down_n = 1'b0;
      n = 0;
      repeat (4) @(negedge core_clk_i);
      repeat (3000) begin
         @(negedge core_clk_i);
         n += (sv !== 1'b0);
      end
      check(n, 32'h0);
      power_down_n = 1'b1;
      words(1'b0, 1'b1);
      $display("power-down done");
      // Frozen source: fault after the timeout, then relock unaided
      src_ce = 1'b0;
      repeat (6500) @(negedge core_clk_i);
      check(err, 32'h1);
      check(rate, FS_NONE);
      src_ce = 1'b1;
      words(1'b0, 1'b1);
      check(rate, FS_192);
      $display("timeout recovery done");
      finish_test();
   end
endmodule
